// ### src/bmw_pkg.sv
// Purpose: Constants and carrier types for the bridge memory window decoder.
// Assumes: Configuration accesses arrive as aligned dwords, with byte enables selecting the bytes written.
// Notes:   Offsets are byte addresses in configuration space.
`default_nettype none
package bmw_pkg;
   localparam logic [7:0]  OFS_MEM_WINDOW   = 8'h20;
   localparam logic [7:0]  OFS_PREF_WINDOW  = 8'h24;
   localparam logic [7:0]  OFS_PREF_BASE_HI = 8'h28;
   localparam logic [7:0]  OFS_PREF_LIM_HI  = 8'h2c;
   localparam logic [7:0]  OFS_IO_UPPER     = 8'h30;
   localparam logic [7:0]  OFS_CAP_PTR      = 8'h34;
   localparam logic [31:0] RST_MEM_WINDOW   = 32'h0000_0000;
   localparam logic [31:0] RST_PREF_WINDOW  = 32'h0001_0001;
   localparam logic [31:0] RST_PREF_HI      = 32'h0000_0000;
   localparam logic [31:0] RST_RDATA        = 32'h0000_0000;
   localparam logic [31:0] IO_UPPER_VALUE   = 32'h0000_0000;
   localparam logic [7:0]  CAP_PTR_VALUE    = 8'h50;
   localparam logic [3:0]  ADDR_WIDTH_IND   = 4'h1;
   localparam int          LIMIT_LSB        = 20;
   localparam int          BASE_LSB         = 4;
   localparam int          IND_HI_LSB       = 16;
   localparam int          IND_LO_LSB       = 0;

   // One configuration access from the hub side.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } bmw_cfg_req_type;

   // One memory address presented for a routing decision.
   typedef struct packed {
      logic        valid;
      logic        is64;
      logic [63:0] addr;
   } bmw_mem_req_type;
endpackage : bmw_pkg
`default_nettype wire

// ### src/bmw_window_decode.sv
// Purpose: Memory window registers and hit decode for a hub to PCI bridge.
// Assumes: Enable bits come from the command register, kept elsewhere.
// Notes:   Decode outputs are registered, one cycle after the request.
`default_nettype none
module bmw_window_decode
   import bmw_pkg::*;
(
   // Clock and reset.
   input  wire logic            clk,
   input  wire logic            rstn,
   // Configuration access.
   input  wire bmw_cfg_req_type cfg_req,
   output logic [31:0]          cfg_rdata,
   output logic                 cfg_rvalid,
   // Command enables.
   input  wire logic            mem_space_en,
   input  wire logic            bus_master_en,
   // Hub side memory request.
   input  wire bmw_mem_req_type hub_req,
   output logic                 hub_to_pci,
   // PCI side memory request.
   input  wire bmw_mem_req_type pci_req,
   output logic                 pci_to_hub
);

   ////////////////////////////////////////////////////////////////////////////
   logic [31:0] mem_window_reg, mem_window_next;
   logic [31:0] pref_window_reg, pref_window_next;
   logic [31:0] pref_base_hi_reg, pref_base_hi_next;
   logic [31:0] pref_lim_hi_reg, pref_lim_hi_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        rvalid_reg, rvalid_next;
   logic        hub_hit_reg, hub_hit_next;
   logic        pci_fwd_reg, pci_fwd_next;

   function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Base inclusive, limit exclusive, both on 1 MB units of the low dword.
   function automatic logic in_range(input logic [31:0] win, input logic [31:0] a);
      return (a[31:LIMIT_LSB] >= win[BASE_LSB +: 12])
          && (a[31:LIMIT_LSB] <  win[31:LIMIT_LSB]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic hub_mem_hit, hub_pref_hit, pci_mem_hit, pci_pref_hit;

   function automatic logic pref_hit(input bmw_mem_req_type q,
                                     input logic [31:0] win,
                                     input logic [31:0] bhi,
                                     input logic [31:0] lhi);
      logic [43:0] a, lo, hi;
      a  = {(q.is64 ? q.addr[63:32] : 32'h0000_0000), q.addr[31:20]};
      lo = {bhi, win[BASE_LSB +: 12]};
      hi = {lhi, win[31:LIMIT_LSB]};
      return (a >= lo) && (a < hi);
   endfunction

   always_comb begin
      hub_mem_hit  = in_range(mem_window_reg, hub_req.addr[31:0]) && !hub_req.is64;
      pci_mem_hit  = in_range(mem_window_reg, pci_req.addr[31:0]) && !pci_req.is64;
      hub_pref_hit = pref_hit(hub_req, pref_window_reg, pref_base_hi_reg, pref_lim_hi_reg);
      pci_pref_hit = pref_hit(pci_req, pref_window_reg, pref_base_hi_reg, pref_lim_hi_reg);
      hub_hit_next = hub_req.valid && mem_space_en && (hub_mem_hit || hub_pref_hit);
      pci_fwd_next = pci_req.valid && bus_master_en
                     && !(pci_mem_hit || pci_pref_hit);
   end

   // Decisions are registered so both routing outputs change only on the clock, or clear at once on reset.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hub_hit_reg <= 1'b0;
         pci_fwd_reg <= 1'b0;
      end else begin
         hub_hit_reg <= hub_hit_next;
         pci_fwd_reg <= pci_fwd_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [31:0] pref_wr;

   always_comb begin
      mem_window_next  = mem_window_reg;
      pref_window_next = pref_window_reg;
      pref_base_hi_next = pref_base_hi_reg;
      pref_lim_hi_next = pref_lim_hi_reg;
      pref_wr          = merge_be(pref_window_reg, cfg_req.wdata, cfg_req.be);
      if (cfg_req.wr) begin
         case (cfg_req.addr)
            OFS_MEM_WINDOW: begin
               mem_window_next = merge_be(mem_window_reg, cfg_req.wdata, cfg_req.be);
            end
            OFS_PREF_WINDOW: begin
               // Width indicators are not writable and always agree.
               pref_window_next = {pref_wr[31:20], ADDR_WIDTH_IND,
                                   pref_wr[15:4], ADDR_WIDTH_IND};
            end
            OFS_PREF_BASE_HI: begin
               pref_base_hi_next = merge_be(pref_base_hi_reg, cfg_req.wdata, cfg_req.be);
            end
            OFS_PREF_LIM_HI: begin
               pref_lim_hi_next = merge_be(pref_lim_hi_reg, cfg_req.wdata, cfg_req.be);
            end
            default: begin
            end
         endcase
      end
      rvalid_next = cfg_req.rd;
      case (cfg_req.addr)
         OFS_MEM_WINDOW:   rdata_next = mem_window_reg;
         OFS_PREF_WINDOW:  rdata_next = pref_window_reg;
         OFS_PREF_BASE_HI: rdata_next = pref_base_hi_reg;
         OFS_PREF_LIM_HI:  rdata_next = pref_lim_hi_reg;
         OFS_IO_UPPER:     rdata_next = IO_UPPER_VALUE;
         OFS_CAP_PTR:      rdata_next = {24'h00_0000, CAP_PTR_VALUE};
         default:          rdata_next = 32'h0000_0000;
      endcase
      if (!cfg_req.rd) begin
         rdata_next = rdata_reg;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mem_window_reg   <= RST_MEM_WINDOW;
         pref_window_reg  <= RST_PREF_WINDOW;
         pref_base_hi_reg <= RST_PREF_HI;
         pref_lim_hi_reg  <= RST_PREF_HI;
         rdata_reg        <= RST_RDATA;
         rvalid_reg       <= 1'b0;
      end else begin
         mem_window_reg   <= mem_window_next;
         pref_window_reg  <= pref_window_next;
         pref_base_hi_reg <= pref_base_hi_next;
         pref_lim_hi_reg  <= pref_lim_hi_next;
         rdata_reg        <= rdata_next;
         rvalid_reg       <= rvalid_next;
      end
   end

   assign cfg_rdata  = rdata_reg;
   assign cfg_rvalid = rvalid_reg;
   assign hub_to_pci = hub_hit_reg;
   assign pci_to_hub = pci_fwd_reg;

   ////////////////////////////////////////////////////////////////////////////
   a_hub_needs_enable: assert property (@(posedge clk) disable iff (!rstn)
      hub_to_pci |-> $past(mem_space_en) && $past(hub_req.valid))
      else $error("hub forward without memory enable");
   a_pci_needs_enable: assert property (@(posedge clk) disable iff (!rstn)
      pci_to_hub |-> $past(bus_master_en) && $past(pci_req.valid))
      else $error("pci forward without master enable");
   a_pci_inside_kept: assert property (@(posedge clk) disable iff (!rstn)
      (pci_req.valid && !pci_req.is64 && pci_req.addr[31:20] == mem_window_reg[15:4]
       && pci_req.addr[31:20] < mem_window_reg[31:20]) |=> !pci_to_hub)
      else $error("pci access inside window forwarded");
   a_pci_outside_fwd: assert property (@(posedge clk) disable iff (!rstn)
      (pci_req.valid && bus_master_en && !pci_req.is64 && !pci_pref_hit
       && pci_req.addr[31:20] >= mem_window_reg[31:20]) |=> pci_to_hub)
      else $error("pci access outside windows kept");
   a_limit_exclusive: assert property (@(posedge clk) disable iff (!rstn)
      (hub_req.valid && mem_space_en && !hub_req.is64 && !hub_pref_hit
       && hub_req.addr[31:20] >= mem_window_reg[31:20]) |=> !hub_to_pci)
      else $error("hit at or above limit");
   a_base_inclusive: assert property (@(posedge clk) disable iff (!rstn)
      (hub_req.valid && mem_space_en && !hub_req.is64
       && hub_req.addr[31:20] == mem_window_reg[15:4]
       && hub_req.addr[31:20] < mem_window_reg[31:20]) |=> hub_to_pci)
      else $error("base address missed");
   a_ind_agree: assert property (@(posedge clk) disable iff (!rstn)
      pref_window_reg[19:16] == ADDR_WIDTH_IND && pref_window_reg[3:0] == ADDR_WIDTH_IND)
      else $error("width indicators disagree");
   a_upper_write: assert property (@(posedge clk) disable iff (!rstn)
      (cfg_req.wr && cfg_req.addr == OFS_PREF_BASE_HI && cfg_req.be == 4'hf)
      ##1 (cfg_req.rd && cfg_req.addr == OFS_PREF_BASE_HI && !cfg_req.wr)
      |=> cfg_rdata == $past(cfg_req.wdata, 2))
      else $error("upper base not read back");
   a_rvalid_pulse: assert property (@(posedge clk) disable iff (!rstn)
      cfg_req.rd |=> cfg_rvalid)
      else $error("read not answered");
   a_rvalid_idle: assert property (@(posedge clk) disable iff (!rstn)
      !cfg_req.rd |=> !cfg_rvalid)
      else $error("read valid without a read");
   a_io_zero: assert property (@(posedge clk) disable iff (!rstn)
      (cfg_req.rd && cfg_req.addr == OFS_IO_UPPER) |=> cfg_rvalid && cfg_rdata == 32'h0)
      else $error("io upper not zero");
   a_cap_ptr: assert property (@(posedge clk) disable iff (!rstn)
      (cfg_req.rd && cfg_req.addr == OFS_CAP_PTR) |=> cfg_rdata == 32'h0000_0050)
      else $error("capability pointer wrong");
   a_pref_upper: assert property (@(posedge clk) disable iff (!rstn)
      (hub_req.valid && hub_req.is64 && hub_req.addr[63:32] < pref_base_hi_reg)
      |=> !hub_to_pci)
      else $error("64-bit hit below upper base");
   a_pref_above_lim: assert property (@(posedge clk) disable iff (!rstn)
      (hub_req.valid && hub_req.is64 && hub_req.addr[63:32] > pref_lim_hi_reg)
      |=> !hub_to_pci)
      else $error("64-bit hit above upper limit");

endmodule // bmw_window_decode
`default_nettype wire

// ### verification/bmw_req_source.sv
// Purpose: Far side model issuing memory requests to both decode ports.
// Assumes: One request per call, valid for a single clock.
// Notes:   Released address lines show the inverse, never the old value.
`default_nettype none
module bmw_req_source
   import bmw_pkg::*;
(
   // Clock.
   input  wire logic          clk,
   // Requests.
   output var bmw_mem_req_type hub_req,
   output var bmw_mem_req_type pci_req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      hub_req = '0;
      pci_req = '0;
   end
   task automatic issue(input logic [63:0] a, input logic s64);
      @(negedge clk);
      hub_req <= '{1'b1, s64, a};
      pci_req <= '{1'b1, s64, a};
      @(negedge clk);
      hub_req <= '{1'b0, ~s64, ~a};
      pci_req <= '{1'b0, ~s64, ~a};
   endtask
endmodule // bmw_req_source
`default_nettype wire

// ### verification/bmw_window_decode_tb_top.sv
// Purpose: Self-checking bench for the memory window decoder.
// Assumes: Decode and read answers come one cycle after the request.
// Notes:   A shadow model of the registers predicts read data and routing; valid and reset checks use fixed values.
`default_nettype none
module bridge_memory_window_decode_tb_top
   import bmw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rstn, mem_space_en, bus_master_en, cfg_rvalid, hub_to_pci, pci_to_hub;
   bmw_cfg_req_type cfg_req;
   bmw_mem_req_type hub_req, pci_req;
   logic [31:0] cfg_rdata, sh [0:3];
   int n_mismatch, total_checks, seed, i, f;
   logic [63:0] a;
   logic [11:0] fl [0:5];
   bmw_window_decode dut (.clk(clk), .rstn(rstn), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
      .cfg_rvalid(cfg_rvalid), .mem_space_en(mem_space_en), .bus_master_en(bus_master_en),
      .hub_req(hub_req), .hub_to_pci(hub_to_pci), .pci_req(pci_req), .pci_to_hub(pci_to_hub));
   bmw_req_source src (.clk(clk), .hub_req(hub_req), .pci_req(pci_req));
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   function automatic logic [31:0] exp_rd(input logic [7:0] o);
      if (o >= 8'h20 && o <= 8'h2c) return sh[(o - 8'h20) >> 2];
      return (o == 8'h34) ? 32'h0000_0050 : 32'h0000_0000;
   endfunction
   task automatic cfg_wr(input logic [7:0] o, input logic [3:0] be, input logic [31:0] d);
      @(negedge clk);
      cfg_req <= '{1'b1, 1'b0, o, be, d};
      @(negedge clk);
      cfg_req <= '0;
      chk("rvalid idle", cfg_rvalid, 1'b0);
      if (o >= 8'h20 && o <= 8'h2c) for (int b = 0; b < 4; b++)
         if (be[b]) sh[(o - 8'h20) >> 2][8*b +: 8] = d[8*b +: 8];
      sh[1] = (sh[1] & 32'hfff0_fff0) | 32'h0001_0001;
   endtask
   task automatic cfg_rd(input logic [7:0] o);
      @(negedge clk);
      cfg_req <= '{1'b0, 1'b1, o, 4'h0, 32'h0000_0000};
      @(negedge clk);
      cfg_req <= '0;
      chk("rvalid", cfg_rvalid, 1'b1);
      chk("rdata", cfg_rdata, exp_rd(o));
   endtask
   task automatic route(input logic [63:0] ad, input logic s64);
      logic hm, hp;
      hm = !s64 && ad[31:20] >= sh[0][15:4] && ad[31:20] < sh[0][31:20];
      hp = {(s64 ? ad[63:32] : 32'h0), ad[31:20]} >= {sh[2], sh[1][15:4]} &&
           {(s64 ? ad[63:32] : 32'h0), ad[31:20]} < {sh[3], sh[1][31:20]};
      src.issue(ad, s64);
      chk("hub_to_pci", hub_to_pci, mem_space_en && (hm || hp));
      chk("pci_to_hub", pci_to_hub, bus_master_en && !(hm || hp));
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #200000;
      n_mismatch++;
      complete_run();
   end
   initial begin
      seed = 32'ha9c9;
      rstn = 1'b0;
      cfg_req = '0;
      {mem_space_en, bus_master_en} = 2'b11;
      sh = '{32'h0, 32'h0001_0001, 32'h0, 32'h0};
      repeat (10) @(negedge clk);
      rstn <= 1'b1;
      for (f = 8'h20; f <= 8'h38; f += 4) cfg_rd(f[7:0]);
      $display("test reset values done");
      for (f = 8'h20; f <= 8'h38; f += 4) cfg_wr(f[7:0], 4'hf, 32'hffff_ffff);
      cfg_wr(8'h28, 4'h5, 32'h1234_5678);
      for (f = 8'h20; f <= 8'h38; f += 4) cfg_rd(f[7:0]);
      @(negedge clk);
      cfg_req <= '{1'b1, 1'b0, OFS_PREF_BASE_HI, 4'hf, 32'h0000_0002};
      @(negedge clk);
      cfg_req <= '{1'b0, 1'b1, OFS_PREF_BASE_HI, 4'h0, 32'h0000_0000};
      sh[2] = 32'h0000_0002;
      @(negedge clk);
      cfg_req <= '0;
      chk("rdata back to back", cfg_rdata, sh[2]);
      $display("test register access done");
      rstn <= 1'b0;
      @(negedge clk);
      chk("reset rvalid", cfg_rvalid, 1'b0);
      chk("reset rdata", cfg_rdata, RST_RDATA);
      chk("reset hub_to_pci", hub_to_pci, 1'b0);
      chk("reset pci_to_hub", pci_to_hub, 1'b0);
      repeat (9) @(negedge clk);
      rstn <= 1'b1;
      sh = '{RST_MEM_WINDOW, RST_PREF_WINDOW, RST_PREF_HI, RST_PREF_HI};
      for (f = 8'h20; f <= 8'h38; f += 4) cfg_rd(f[7:0]);
      $display("test mid-run reset done");
      for (i = 0; i < 400; i++) begin
         if (i % 8 == 0) begin
            cfg_wr(8'h20, 4'hf, $random(seed) & 32'h00f0_00f0);
            cfg_wr(8'h24, 4'hf, $random(seed) & 32'h00f0_00f0);
            cfg_wr(8'h28, 4'hf, $random(seed) & 32'h3);
            cfg_wr(8'h2c, 4'hf, $random(seed) & 32'h3);
         end
         fl = '{sh[0][15:4], sh[0][15:4] - 12'h001, sh[0][31:20], sh[0][31:20] - 12'h001,
                sh[1][15:4], sh[1][31:20]};
         f = $random(seed);
         a[63:32] = $random(seed) & 32'h3;
         a[31:20] = fl[(f & 32'h7fff) % 6] + {11'h000, f[16]};
         a[19:0] = f[31:12];
         @(negedge clk);
         {mem_space_en, bus_master_en} <= f[9:8];
         route(a, f[10]);
      end
      $display("test random decode done");
      complete_run();
   end
endmodule // bridge_memory_window_decode_tb_top
`default_nettype wire
